// ### hw/spi_sel_cfg.svh
// Purpose: offsets, field positions and reset values of the slave port
// Assumes: register index times four is the byte address on the bus
// Notes: definitions only
`ifndef SPI_SEL_CFG_SVH
`define SPI_SEL_CFG_SVH
// register indices (byte address = index * 4)
`define IDX_RXB 14'h3d10
`define IDX_TXB 14'h3d11
`define IDX_TCNTL 14'h3d12
`define IDX_TCNTH 14'h3d13
`define IDX_CON0 14'h3d14
`define IDX_CON1 14'h3d15
`define IDX_CON2 14'h3d16
`define IDX_STAT 14'h3d17
`define IDX_TWID 14'h3d18
`define IDX_BAUD 14'h3d19
`define IDX_INTF 14'h3d1a
`define IDX_INTE 14'h3d1b
`define IDX_CLKS 14'h3d1c
`define IDX_ICLR 14'h3d1d
`define IDX_PAD 14'h3d1e
// field positions
`define CON0_EN 7
`define CON1_CKE 6
`define CON1_CKP 5
`define CON1_SSP 2
`define CON2_FLT 6
`define CON2_FORCE_SELECT_ACTIVE_BIT 2
`define CON2_TXR 1
`define CON2_RXR 0
`define STAT_TXBE 5
`define STAT_CLRBF 2
`define STAT_RXBF 0
`define INT_TCZ 6
`define INT_SOS 5
`define INT_EOS 4
`define INT_RXO 2
`define INT_TXU 1
`define PAD_PIN_DIRECTION_BIT 3
`define PAD_LAT 4
`define PAD_FWD 5
// reset values
`define CON1_RST 8'h04
`define PAD_RST 8'h08
`define SYNC_RST 3'h7
`endif

// ### hw/spi_sel_pkg.sv
// Purpose: types shared by the slave port
// Assumes: nothing beyond the config header
// Notes: whole module state is one packed struct
package spi_sel_pkg;
    typedef enum logic {LNK_IDLE, LNK_ACTIVE} link_state_t;
    typedef struct packed {
        link_state_t lnk;
        logic [2:0] ss_s, sck_s, sdi_s;
        logic ss_f, sck_f, sdi_f;
        logic [7:0] con0, con1, con2, twid, baud, clks, inte, intf, pad;
        logic [15:0] tcnt, tcnt_rem;
        logic [7:0] rxb, txb, sr;
        logic rx_full, tx_full, seen_clk;
        logic [2:0] bit_cnt;
        logic sdo, sdo_pin, sdo_oe, sck_out;
        logic ack;
        logic [31:0] rdata;
    } state_t;
endpackage : spi_sel_pkg

// ### hw/spi_slave_port.sv
// Purpose: spi slave port with select framing, fault detection and daisy chaining
// Assumes: core_clk_i at 40 MHz, far faster than the serial clock
// Notes: serial input pins pass three flops; registers on an avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
`include "spi_sel_cfg.svh"

module spi_slave_port (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [7:0] ss_pins_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic sck_o,
    output logic sck_oe_o,
    output logic irq_o
);

    // transfer length in bits, a zero width field means eight
    function automatic logic [3:0] word_len(input logic [7:0] tw);
        word_len = (tw[2:0] == 3'h0) ? 4'h8 : {1'b0, tw[2:0]};
    endfunction : word_len

    // keeps only the bits of the current word length
    function automatic logic [7:0] word_mask(input logic [7:0] tw);
        word_mask = 8'hff >> (4'h8 - word_len(tw));
    endfunction : word_mask

    // the bit that goes out next: top of the word
    function automatic logic top_bit(input logic [7:0] sr, input logic [7:0] tw);
        logic [3:0] i;
        i = word_len(tw) - 4'h1;
        top_bit = sr[i[2:0]];
    endfunction : top_bit

    spi_sel_pkg::state_t q; // registered state
    spi_sel_pkg::state_t n; // next state
    logic sel_act; // effective select, after polarity and force
    logic sck_chg; // filtered serial clock is changing this cycle
    logic lead; // idle-to-active clock edge
    logic samp; // edge that samples the data input
    logic shft; // edge that changes the data output
    logic word_done; // last bit of a word sampled
    logic [7:0] rx_word; // word just completed
    logic in_prog; // transfer counts as in progress
    logic [13:0] idx; // register index from the byte address
    logic req; // bus request present
    logic wr; // write takes effect this edge
    logic rd; // read completes this edge

    // state register: constants only under reset
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.con1 <= `CON1_RST;
            q.pad <= `PAD_RST;
            q.ss_s <= `SYNC_RST;
            q.ss_f <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // bus answers one cycle after the request appears
    assign avs_waitrequest_o = req & ~q.ack;
    assign avs_readdata_o = q.rdata;
    assign sdo_o = q.sdo_pin;
    assign sdo_oe_o = q.sdo_oe;
    assign sck_o = q.sck_out;
    assign sck_oe_o = q.pad[`PAD_FWD];
    // level interrupt while any enabled status bit stands
    assign irq_o = |(q.intf & q.inte);

    // all next-state logic
    always_comb begin
        n = q;
        req = avs_read_i | avs_write_i;
        idx = avs_address_i[15:2];
        wr = q.ack & avs_write_i & avs_byteenable_i[0];
        rd = q.ack & avs_read_i;
        n.ack = req & ~q.ack;

        // three-flop synchronisers; a change counts once stages two and three agree
        n.ss_s = {q.ss_s[1:0], ss_pins_i[q.pad[2:0]]};
        n.sck_s = {q.sck_s[1:0], sck_i};
        n.sdi_s = {q.sdi_s[1:0], sdi_i};
        if (q.ss_s[1] == q.ss_s[2]) begin
            n.ss_f = q.ss_s[2];
        end
        if (q.sck_s[1] == q.sck_s[2]) begin
            n.sck_f = q.sck_s[2];
        end
        if (q.sdi_s[1] == q.sdi_s[2]) begin
            n.sdi_f = q.sdi_s[2];
        end

        // effective select: polarity applied, force overrides the pin
        sel_act = q.con0[`CON0_EN] &
            (q.con2[`CON2_FORCE_SELECT_ACTIVE_BIT] | (q.ss_f ^ q.con1[`CON1_SSP]));

        // clock edges against the idle level chosen by polarity bit
        sck_chg = (q.sck_s[1] == q.sck_s[2]) && (q.sck_s[2] != q.sck_f);
        lead = sck_chg && (q.sck_s[2] != q.con1[`CON1_CKP]);
        samp = q.con1[`CON1_CKE] ? lead : (sck_chg & ~lead);
        shft = q.con1[`CON1_CKE] ? (sck_chg & ~lead) : lead;

        rx_word = {q.sr[6:0], q.sdi_f} & word_mask(q.twid);
        word_done = 1'b0;
        // mid-word, or words still owed by the transfer counter
        in_prog = (q.bit_cnt != 3'h0) || (q.seen_clk && q.tcnt_rem != 16'h0000);

        // register read data, captured while the request waits
        n.rdata = '0;
        if (req && !q.ack && avs_read_i) begin
            case (idx)
                `IDX_RXB: n.rdata[7:0] = q.rxb;
                `IDX_TCNTL: n.rdata[7:0] = q.tcnt[7:0];
                `IDX_TCNTH: n.rdata[7:0] = q.tcnt[15:8];
                `IDX_CON0: n.rdata[7:0] = q.con0;
                `IDX_CON1: n.rdata[7:0] = q.con1;
                // busy shows the link state in the top bit
                `IDX_CON2: n.rdata[7:0] = {q.lnk == spi_sel_pkg::LNK_ACTIVE, q.con2[6:0]};
                `IDX_STAT: begin
                    n.rdata[`STAT_TXBE] = ~q.tx_full;
                    n.rdata[`STAT_RXBF] = q.rx_full;
                end
                `IDX_TWID: n.rdata[7:0] = q.twid;
                `IDX_BAUD: n.rdata[7:0] = q.baud;
                `IDX_INTF: n.rdata[7:0] = q.intf;
                `IDX_INTE: n.rdata[7:0] = q.inte;
                `IDX_CLKS: n.rdata[7:0] = q.clks;
                `IDX_PAD: n.rdata[7:0] = q.pad;
                default: n.rdata = '0; // write-only and unmapped read zero
            endcase
        end

        // reading the receive buffer frees it
        if (rd && idx == `IDX_RXB) begin
            n.rx_full = 1'b0;
        end

        // register writes; low byte lane only, others ignored
        if (wr) begin
            case (idx)
                `IDX_TXB: begin
                    n.txb = avs_writedata_i[7:0];
                    n.tx_full = 1'b1;
                end
                `IDX_TCNTL: n.tcnt[7:0] = avs_writedata_i[7:0];
                `IDX_TCNTH: n.tcnt[15:8] = avs_writedata_i[7:0];
                `IDX_CON0: n.con0 = avs_writedata_i[7:0];
                `IDX_CON1: n.con1 = avs_writedata_i[7:0];
                // fault bit only clears by writing zero; busy is read-only
                `IDX_CON2: n.con2 = {1'b0, q.con2[`CON2_FLT] & avs_writedata_i[6],
                    3'h0, avs_writedata_i[2:0]};
                `IDX_STAT: begin
                    if (avs_writedata_i[`STAT_CLRBF]) begin
                        n.rx_full = 1'b0;
                        n.tx_full = 1'b0;
                    end
                end
                `IDX_TWID: n.twid = {5'h00, avs_writedata_i[2:0]};
                `IDX_BAUD: n.baud = avs_writedata_i[7:0];
                `IDX_INTE: n.inte = avs_writedata_i[7:0];
                `IDX_CLKS: n.clks = avs_writedata_i[7:0];
                `IDX_ICLR: n.intf = q.intf & ~avs_writedata_i[7:0];
                `IDX_PAD: n.pad = avs_writedata_i[7:0];
                default: n.ack = n.ack; // unmapped writes are acked and dropped
            endcase
        end

        // link state machine; events set after bus clears so a set wins
        case (q.lnk)
            spi_sel_pkg::LNK_IDLE: begin
                // clock edges are not looked at here at all
                if (sel_act) begin
                    n.lnk = spi_sel_pkg::LNK_ACTIVE;
                    n.intf[`INT_SOS] = 1'b1;
                    n.bit_cnt = 3'h0;
                    n.seen_clk = 1'b0;
                    n.tcnt_rem = q.tcnt;
                    if (q.tx_full) begin
                        n.sr = q.txb;
                        n.tx_full = (wr && idx == `IDX_TXB);
                    end else begin
                        // nothing queued: echo the last word held; flag stays sticky
                        n.intf[`INT_TXU] = n.intf[`INT_TXU] | q.con2[`CON2_TXR];
                    end
                    // first bit out before any clock edge
                    n.sdo = top_bit(n.sr, q.twid);
                end
            end
            spi_sel_pkg::LNK_ACTIVE: begin
                if (!sel_act) begin
                    n.lnk = spi_sel_pkg::LNK_IDLE;
                    n.intf[`INT_EOS] = 1'b1;
                    if (in_prog) begin
                        n.con2[`CON2_FLT] = 1'b1;
                    end
                    // partial word is dropped, next select starts fresh
                    n.bit_cnt = 3'h0;
                    n.seen_clk = 1'b0;
                end else begin
                    if (shft) begin
                        n.sdo = top_bit(q.sr, q.twid);
                    end
                    if (samp) begin
                        n.seen_clk = 1'b1;
                        n.sr = {q.sr[6:0], q.sdi_f};
                        n.bit_cnt = q.bit_cnt + 3'h1;
                        if ({1'b0, q.bit_cnt} == word_len(q.twid) - 4'h1) begin
                            word_done = 1'b1;
                            n.bit_cnt = 3'h0;
                            // receive side
                            if (q.con2[`CON2_RXR]) begin
                                if (q.rx_full && !(rd && idx == `IDX_RXB)) begin
                                    n.intf[`INT_RXO] = 1'b1; // old word kept
                                end else begin
                                    n.rxb = rx_word;
                                    n.rx_full = 1'b1;
                                end
                            end
                            // transfer counter paces the expected length
                            if (q.tcnt_rem != 16'h0000) begin
                                n.tcnt_rem = q.tcnt_rem - 16'h0001;
                                if (q.tcnt_rem == 16'h0001) begin
                                    n.intf[`INT_TCZ] = 1'b1;
                                end
                            end
                            // next word: queued data, or an exact copy of this one
                            if (q.tx_full) begin
                                n.sr = q.txb;
                                n.tx_full = (wr && idx == `IDX_TXB);
                            end else begin
                                n.sr = rx_word;
                                n.intf[`INT_TXU] = n.intf[`INT_TXU] | q.con2[`CON2_TXR];
                            end
                        end
                    end
                end
            end
            default: n.lnk = spi_sel_pkg::LNK_IDLE;
        endcase

        // data pin: driven while selected, else direction and latch bits decide
        if (n.lnk == spi_sel_pkg::LNK_ACTIVE) begin
            n.sdo_pin = n.sdo;
            n.sdo_oe = 1'b1;
        end else begin
            n.sdo_pin = q.pad[`PAD_LAT];
            n.sdo_oe = ~q.pad[`PAD_PIN_DIRECTION_BIT];
        end
        // clock output is the filtered clock input, a few cycles late
        n.sck_out = q.sck_f;
    end

    // link start follows an active select within one cycle
    sel_start_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_IDLE && sel_act) |=> (q.lnk == spi_sel_pkg::LNK_ACTIVE
        && q.bit_cnt == 3'h0 && q.intf[`INT_SOS]))
        else $error("select did not start a transfer");

    // dropping select returns to idle with counter cleared
    sel_end_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_ACTIVE && !sel_act) |=> (q.lnk == spi_sel_pkg::LNK_IDLE
        && q.bit_cnt == 3'h0 && !q.seen_clk))
        else $error("select release did not reset receiver");

    // pin drives while selected
    sdo_drive_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_ACTIVE) |-> (sdo_oe_o && sdo_o == q.sdo))
        else $error("data pin not driven while selected");

    // idle pin follows direction and latch bits one cycle later
    sdo_idle_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_IDLE && !sel_act) |=>
        (sdo_oe_o == !$past(q.pad[`PAD_PIN_DIRECTION_BIT]) && sdo_o == $past(q.pad[`PAD_LAT])))
        else $error("idle data pin wrong");

    // clock edges leave the shift register and bit count alone while deselected
    sck_ignore_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_IDLE && !sel_act && sck_chg) |=>
        ($stable(q.sr) && q.bit_cnt == 3'h0))
        else $error("clock acted while deselected");

    // mid-word select loss raises the fault flag
    fault_set_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_ACTIVE && !sel_act && q.bit_cnt != 3'h0) |=>
        q.con2[`CON2_FLT])
        else $error("select fault not flagged");

    // last counted word raises counter-zero
    count_end_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (word_done && q.tcnt_rem == 16'h0001) |=> (q.intf[`INT_TCZ] && q.tcnt_rem == 16'h0000))
        else $error("transfer count end missed");

    // a pin sitting at the inactive level of the polarity bit keeps the link idle
    polarity_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_IDLE && !q.con2[`CON2_FORCE_SELECT_ACTIVE_BIT] &&
        q.ss_f == q.con1[`CON1_SSP]) |=> (q.lnk == spi_sel_pkg::LNK_IDLE))
        else $error("select polarity wrong");

    // forced select keeps the link active
    force_sel_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.con0[`CON0_EN] && q.con2[`CON2_FORCE_SELECT_ACTIVE_BIT]) ##1 (q.con0[`CON0_EN] &&
        q.con2[`CON2_FORCE_SELECT_ACTIVE_BIT]) |-> (q.lnk == spi_sel_pkg::LNK_ACTIVE))
        else $error("forced select not active");

    // unqueued next word is the received word
    daisy_echo_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (word_done && !q.tx_full) |=> (q.sr == $past(rx_word)))
        else $error("daisy echo word wrong");

    // forwarded clock tracks the filtered input
    clk_fwd_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (sck_chg && q.pad[`PAD_FWD]) |-> ##2 (sck_o == $past(q.sck_s[2], 2)))
        else $error("clock output not following input");

    // with edge bit set the first bit stands at select start
    cke_early_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_IDLE && sel_act && q.con1[`CON1_CKE]) |=> ##1
        (sdo_o == $past(top_bit(q.sr, q.twid))))
        else $error("first bit not valid early");

    // filtered select holds while stages disagree
    ss_sync_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.ss_s[1] != q.ss_s[2]) |=> $stable(q.ss_f))
        else $error("select filter changed early");

    // select lost while counted words are still owed is a fault as well
    count_fault_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (q.lnk == spi_sel_pkg::LNK_ACTIVE && !sel_act && q.seen_clk &&
        q.tcnt_rem != 16'h0000) |=> q.con2[`CON2_FLT])
        else $error("counted transfer cut without fault");

    // a full receive buffer keeps its old word and flags the overflow
    rx_keep_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (word_done && q.con2[`CON2_RXR] && q.rx_full && !(rd && idx == `IDX_RXB)) |=>
        ($stable(q.rxb) && q.intf[`INT_RXO]))
        else $error("receive overflow lost the old word");

    // status flags are sticky: only the clear register takes them down
    flags_sticky_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        !(wr && idx == `IDX_ICLR) |=> ((q.intf & $past(q.intf)) == $past(q.intf)))
        else $error("interrupt flag dropped without a clear");

    // an unqueued word with the underrun enable set raises the underrun flag
    tx_under_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (word_done && !q.tx_full && q.con2[`CON2_TXR]) |=> q.intf[`INT_TXU])
        else $error("transmit underrun not flagged");

endmodule : spi_slave_port
`default_nettype wire

// ### dv/spi_master_model.sv
// Purpose: spi master model driving select, serial clock and data
// Assumes: core clock 40 MHz; link clock period 8 core cycles (200 ns)
// Notes: select is asserted-high here; the bench maps it to the pin level
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input wire logic clk_i,
    input wire logic cpol_i,
    input wire logic sdo_i,
    output var logic sel_o,
    output logic sck_o,
    output var logic sdi_o
);
    logic sck_q; // clock before polarity
    logic busy_q; // frame in progress
    // clock stands at its idle level outside frames unless sck_set moves it
    assign sck_o = sck_q ^ cpol_i; // idle level matches the slave setting
    initial begin
        sel_o = 1'b0; // select off until the master is ready
        sck_q = 1'b0;
        sdi_o = 1'b0;
        busy_q = 1'b0;
    end
    // data line toggles between frames so a stale bit never passes for data
    always @(posedge clk_i) begin
        if (!busy_q) begin
            sdi_o <= ~sdi_o;
        end
    end
    // one frame of nb bits, msb first; sample on rise, change on fall
    task automatic xfer(input logic [15:0] tx, input int nb, input logic on,
                        output logic [15:0] rx);
        rx = 16'h0;
        busy_q <= 1'b1;
        sel_o <= on; // one select line shared by the whole chain
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            sdi_o <= tx[15 - i];
            repeat (4) @(posedge clk_i);
            sck_q <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx = {rx[14:0], sdo_i}; // late in the phase, slave output settled
            sck_q <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        sel_o <= 1'b0;
        busy_q <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : xfer
    // raw clock level, for forwarding checks outside frames
    task automatic sck_set(input logic v);
        sck_q <= v;
    endtask : sck_set
endmodule : spi_master_model
`default_nettype wire

// ### dv/spi_slave_select_daisy_chain_tb_top.sv
// Purpose: register-level tests of the spi slave port select, fault and chain logic
// Assumes: one wait cycle or more per bus access; mode with edge bit set
// Notes: buffers are cleared before frames so a stale word never causes an overflow
`timescale 1ns/1ps
`default_nettype none
`include "spi_sel_cfg.svh"
module spi_slave_select_daisy_chain_tb_top;
    logic clk, arst_n, rd, wr, waitreq, sck, sdi, sdo, sdo_oe, sck_fwd, sck_oe, irq;
    logic m_sel, cpol, act; // act high means select active-high
    logic [15:0] addr, rx;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [7:0] pins;
    logic [2:0] sel; // pin the master drives
    int n_fail, check_count;
    always #12.5 clk = ~clk;
    // idle pins sit inactive; the driven pin carries the select level
    always_comb begin
        pins = {8{~act}};
        pins[sel] = m_sel ~^ act;
    end
    spi_slave_port DUT (.core_clk_i(clk), .arst_n_i(arst_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .ss_pins_i(pins), .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .sck_o(sck_fwd), .sck_oe_o(sck_oe), .irq_o(irq));
    // undriven data line floats, so a missing drive shows as a mismatch
    spi_master_model m (.clk_i(clk), .cpol_i(cpol), .sdo_i(sdo_oe ? sdo : 1'bz),
        .sel_o(m_sel), .sck_o(sck), .sdi_o(sdi));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [13:0] i, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= {i, 2'b00};
        wdata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        if (n >= 20) n_fail++;
        q = rdata; // taken at the very edge that sees waitrequest low
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic wrt(input logic [13:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask : wrt
    // read, mask the low byte, upper bytes must be zero
    task automatic rdc(input string nm, input logic [13:0] i, input logic [7:0] mk,
                       input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, i, 8'h00, q);
        chk(nm, q & {24'hffffff, mk}, {24'h0, e});
    endtask : rdc
    task automatic frame(input logic [7:0] t, input logic [15:0] s, input int nb,
                         input logic on);
        wrt(`IDX_STAT, 8'h04); // empty both buffers first
        wrt(`IDX_TXB, t);
        m.xfer(s, nb, on, rx);
    endtask : frame
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test;
    end
    initial begin
        clk = 1'b0; arst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 16'h0;
        wdata = 32'h0; be = 4'h1; cpol = 1'b0; act = 1'b0; sel = 3'h3;
        n_fail = 0; check_count = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk("oe at reset", 32'(sdo_oe), 32'h0);
        rdc("con1 reset", `IDX_CON1, 8'hff, 8'h04);
        rdc("pad reset", `IDX_PAD, 8'hff, 8'h08);
        rdc("unmapped", 14'h3d20, 8'hff, 8'h00);
        $display("test reset done");
        wrt(`IDX_PAD, 8'h0b); // map pin 3, tri-state when idle
        wrt(`IDX_CON1, 8'h44);
        wrt(`IDX_CON0, 8'h80);
        wrt(`IDX_CON2, 8'h03); // keep received words, flag underruns
        wrt(`IDX_INTE, 8'h20);
        frame(8'ha5, 16'h3c00, 8, 1'b1);
        chk("sdo word", 32'(rx[7:0]), 32'ha5);
        rdc("rx word", `IDX_RXB, 8'hff, 8'h3c);
        rdc("start end flags", `IDX_INTF, 8'h30, 8'h30);
        @(negedge clk);
        chk("irq on", 32'(irq), 32'h1);
        wrt(`IDX_INTE, 8'h00);
        @(negedge clk);
        chk("irq masked", 32'(irq), 32'h0);
        wrt(`IDX_ICLR, 8'h30);
        rdc("flags cleared", `IDX_INTF, 8'h30, 8'h00);
        $display("test frame done");
        wrt(`IDX_STAT, 8'h04); // no tx word: the chain echoes
        m.xfer(16'h5a00, 16, 1'b1, rx);
        chk("echo", 32'(rx[7:0]), 32'h5a);
        rdc("echo overflow", `IDX_INTF, 8'h06, 8'h06);
        rdc("echo kept word", `IDX_RXB, 8'hff, 8'h5a);
        $display("test echo done");
        frame(8'h00, 16'hff00, 8, 1'b0);
        rdc("no select", `IDX_STAT, 8'h01, 8'h00);
        @(negedge clk);
        chk("idle tri-state", 32'(sdo_oe), 32'h0);
        @(posedge clk) sel <= 3'h0;
        frame(8'h00, 16'hff00, 8, 1'b1);
        rdc("wrong pin", `IDX_STAT, 8'h01, 8'h00);
        sel <= 3'h3;
        wrt(`IDX_PAD, 8'h13);
        repeat (3) @(negedge clk);
        chk("latch drive", {30'h0, sdo_oe, sdo}, 32'h3);
        wrt(`IDX_PAD, 8'h03);
        repeat (3) @(negedge clk);
        chk("latch low", {30'h0, sdo_oe, sdo}, 32'h2);
        wrt(`IDX_PAD, 8'h0b);
        $display("test idle done");
        frame(8'h00, 16'hff00, 3, 1'b1);
        rdc("fault set", `IDX_CON2, 8'h40, 8'h40);
        wrt(`IDX_CON2, 8'h03);
        rdc("fault clear", `IDX_CON2, 8'h40, 8'h00);
        frame(8'h81, 16'h7e00, 8, 1'b1);
        chk("after fault tx", 32'(rx[7:0]), 32'h81);
        rdc("after fault rx", `IDX_RXB, 8'hff, 8'h7e);
        for (int n = 1; n <= 2; n++) begin
            wrt(`IDX_TCNTL, 8'(n));
            frame(8'h00, 16'h0000, 8, 1'b1);
            rdc("count fault", `IDX_CON2, 8'h40, (n == 2) ? 8'h40 : 8'h00);
            wrt(`IDX_CON2, 8'h03);
        end
        wrt(`IDX_TCNTL, 8'h00);
        $display("test fault done");
        wrt(`IDX_CON1, 8'h60);
        act <= 1'b1;
        cpol <= 1'b1;
        frame(8'hc3, 16'h2400, 8, 1'b1);
        chk("inverted tx", 32'(rx[7:0]), 32'hc3);
        rdc("inverted rx", `IDX_RXB, 8'hff, 8'h24);
        wrt(`IDX_CON1, 8'h44);
        act <= 1'b0;
        cpol <= 1'b0;
        wrt(`IDX_STAT, 8'h04);
        wrt(`IDX_TXB, 8'he7);
        wrt(`IDX_CON2, 8'h07); // force select after loading the word
        m.xfer(16'h1800, 8, 1'b0, rx);
        chk("forced tx", 32'(rx[7:0]), 32'he7);
        rdc("forced rx", `IDX_RXB, 8'hff, 8'h18);
        wrt(`IDX_CON2, 8'h03); // fault flag not looked at while forced
        $display("test polarity done");
        wrt(`IDX_PAD, 8'h2b);
        @(negedge clk);
        chk("fwd enable", 32'(sck_oe), 32'h1);
        @(posedge clk) m.sck_set(1'b1);
        repeat (10) @(negedge clk);
        chk("fwd high", 32'(sck_fwd), 32'h1);
        @(posedge clk) m.sck_set(1'b0);
        repeat (10) @(negedge clk);
        chk("fwd low", 32'(sck_fwd), 32'h0);
        $display("test forward done");
        stop_test;
    end
endmodule : spi_slave_select_daisy_chain_tb_top
`default_nettype wire
